// *** verilog/ais_defs.vh ***
// constants for the converter input select and scan block
// Contract
// - bit 31 picks sample B negative input
// - bit 23 picks sample A negative input
// - bits 27:24 pick sample B positive input
// - bits 19:16 pick sample A positive input
// - unused select bits read zero, ignore writes
// - sixteen scan bits include or skip inputs
// - scan bits map inputs, unit, reference, ground
// - missing scanned inputs convert low reference
// - scan mask upper half reads zero
// - alternate mode: A first, then B, A
// - scan enable takes sample A positive from scan sequence, sample B keeps bits 27:24
// - offset calibration ties both inputs low reference
`ifndef AIS_DEFS_VH
`define AIS_DEFS_VH
// ****************************************
// register offsets
// ****************************************
`define AIS_ADDR_W        4
`define AIS_OFF_MUXSEL    4'h0
`define AIS_OFF_SCANMASK  4'h4
// ****************************************
// field positions
// ****************************************
`define AIS_NEG_B_BIT     31
`define AIS_POS_B_HI      27
`define AIS_POS_B_LO      24
`define AIS_NEG_A_BIT     23
`define AIS_POS_A_HI      19
`define AIS_POS_A_LO      16
`define AIS_MASK_HI       15
`define AIS_MASK_LO       0
`define AIS_SCAN_W        16
`define AIS_SCAN_IDX_W    4
`define AIS_SCAN_CTU      4'hD
`define AIS_SCAN_IREF     4'hE
// ****************************************
// reset values and selector codes
// ****************************************
`define AIS_RST_POS       4'h0
`define AIS_RST_MASK      16'h0000
`define AIS_RST_IDX       4'h0
`define AIS_RST_WORD      32'h00000000
`define AIS_LAST_AN       4'hC
`define AIS_SEL_TEMP      5'h0D
`define AIS_SEL_IREF      5'h0E
`define AIS_SEL_OPEN      5'h0F
`define AIS_SEL_CTU       5'h10
`define AIS_SEL_GND       5'h11
`define AIS_SEL_LOWREF    5'h12
`endif

// *** verilog/ais_input_select.v ***
// converter input multiplexer selection and scan sequencing
//
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ns
`include "ais_defs.vh"

module ais_input_select #(
  parameter NUM_AN = 13
) (
  input  wire        clock,
  input  wire        reset,
  input  wire [3:0]  regAddr,
  input  wire [31:0] regWrData,
  input  wire        regWrite,
  input  wire        regRead,
  output reg  [31:0] regRdData,
  input  wire        alternate_sample_ctrl,
  input  wire        scan_enable_ctrl,
  input  wire        offset_cal_ctrl,
  input  wire        sampleStart,
  output reg  [4:0]  posSelect,
  output reg         negIsAn1,
  output reg         usingSetB,
  output reg  [3:0]  scanIndex
);

  // ****************************************
  // configuration registers
  // ****************************************
  reg        neg_sel_b_q;
  reg        neg_sel_a_q;
  reg [3:0]  pos_sel_b_q;
  reg [3:0]  pos_sel_a_q;
  reg [15:0] scan_mask_bits_q;
  reg        altPhase_q;
  reg [3:0]  scanPtr_q;
  reg [3:0]  scanNext;
  reg [15:0] aboveMask;
  reg [31:0] selWord;
  reg [31:0] maskWord;
  reg        scanArmed_q;
  wire       selWrite;
  wire       maskWrite;
  wire       selRead;
  wire       maskRead;
  wire [3:0] aboveIdx;
  wire       aboveHit;
  wire [3:0] lowestIdx;
  wire       lowestHit;
  wire [3:0] scanCurrent;
  reg [4:0]  posRaw;
  reg [4:0]  posMapped;
  reg        negRaw;
  integer    i;

  // ****************************************
  // register bus decode
  // ****************************************
  // strobes qualified by offset, unmapped offsets match nothing
  assign selWrite  = regWrite && (regAddr == `AIS_OFF_MUXSEL);
  assign maskWrite = regWrite && (regAddr == `AIS_OFF_SCANMASK);
  assign selRead   = regRead && (regAddr == `AIS_OFF_MUXSEL);
  assign maskRead  = regRead && (regAddr == `AIS_OFF_SCANMASK);

  // register writes, reset to zero
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      neg_sel_b_q      <= 1'b0;
      neg_sel_a_q      <= 1'b0;
      pos_sel_b_q      <= `AIS_RST_POS;
      pos_sel_a_q      <= `AIS_RST_POS;
      scan_mask_bits_q <= `AIS_RST_MASK;
    end else begin
      if (selWrite) begin
        neg_sel_b_q <= regWrData[`AIS_NEG_B_BIT];
        pos_sel_b_q <= regWrData[`AIS_POS_B_HI:`AIS_POS_B_LO];
        neg_sel_a_q <= regWrData[`AIS_NEG_A_BIT];
        pos_sel_a_q <= regWrData[`AIS_POS_A_HI:`AIS_POS_A_LO];
      end
      if (maskWrite) begin
        scan_mask_bits_q <= regWrData[`AIS_MASK_HI:`AIS_MASK_LO];
      end
    end
  end

  // readback words, unimplemented bits held at zero
  always @* begin
    selWord  = `AIS_RST_WORD;
    maskWord = `AIS_RST_WORD;
    selWord[`AIS_NEG_B_BIT]              = neg_sel_b_q;
    selWord[`AIS_POS_B_HI:`AIS_POS_B_LO] = pos_sel_b_q;
    selWord[`AIS_NEG_A_BIT]              = neg_sel_a_q;
    selWord[`AIS_POS_A_HI:`AIS_POS_A_LO] = pos_sel_a_q;
    maskWord[`AIS_MASK_HI:`AIS_MASK_LO]  = scan_mask_bits_q;
  end

  // read data one cycle after the strobe, zero otherwise
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      regRdData <= `AIS_RST_WORD;
    end else if (selRead) begin
      regRdData <= selWord;
    end else if (maskRead) begin
      regRdData <= maskWord;
    end else begin
      regRdData <= `AIS_RST_WORD;
    end
  end

  // ****************************************
  // scan sequencing
  // ****************************************
  // set bits strictly above the current pointer
  always @* begin
    aboveMask = `AIS_RST_MASK;
    for (i = 0; i < `AIS_SCAN_W; i = i + 1) begin
      aboveMask[i] = scan_mask_bits_q[i] && (i > scanPtr_q);
    end
  end

  // lowest set bit above the pointer, the next step
  ais_lowest_bit #(
    .WIDTH (`AIS_SCAN_W),
    .IDX_W (`AIS_SCAN_IDX_W)
  ) uAbove (
    .bits  (aboveMask),
    .index (aboveIdx),
    .found (aboveHit)
  );

  // lowest set bit of the whole mask, the wrap target
  ais_lowest_bit #(
    .WIDTH (`AIS_SCAN_W),
    .IDX_W (`AIS_SCAN_IDX_W)
  ) uLowest (
    .bits  (scan_mask_bits_q),
    .index (lowestIdx),
    .found (lowestHit)
  );

  // step up to the next set bit, else wrap to the lowest
  always @* begin
    scanNext = aboveHit ? aboveIdx : lowestIdx;
  end

  // pointer held for the sample, arms on the lowest set bit first
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      scanPtr_q   <= `AIS_RST_IDX;
      scanArmed_q <= 1'b0;
      altPhase_q  <= 1'b0;
    end else begin
      if (!scan_enable_ctrl) begin
        scanArmed_q <= 1'b0;
      end else if (sampleStart) begin
        scanArmed_q <= 1'b1;
        if (scanArmed_q) begin
          scanPtr_q <= scanNext;
        end else begin
          scanPtr_q <= lowestIdx;
        end
      end
      if (!alternate_sample_ctrl) begin
        altPhase_q <= 1'b0;
      end else if (sampleStart) begin
        altPhase_q <= ~altPhase_q;
      end
    end
  end

  // before arming the lowest set bit stands ready
  assign scanCurrent = scanArmed_q ? scanPtr_q : lowestIdx;

  // ****************************************
  // input selection
  // ****************************************
  // pick setting, scan, calibration override
  always @* begin
    negRaw = altPhase_q ? neg_sel_b_q : neg_sel_a_q;
    posRaw = {1'b0, altPhase_q ? pos_sel_b_q : pos_sel_a_q};
    if (scan_enable_ctrl && !altPhase_q) begin
      if (!lowestHit) begin
        posRaw = `AIS_SEL_LOWREF;
      end else if (scanCurrent <= `AIS_LAST_AN) begin
        posRaw = {1'b0, scanCurrent};
      end else if (scanCurrent == `AIS_SCAN_CTU) begin
        posRaw = `AIS_SEL_CTU;
      end else if (scanCurrent == `AIS_SCAN_IREF) begin
        posRaw = `AIS_SEL_IREF;
      end else begin
        posRaw = `AIS_SEL_GND;
      end
    end
    posMapped = posRaw;
    if (posRaw <= {1'b0, `AIS_LAST_AN} && posRaw >= NUM_AN[4:0]) begin
      posMapped = `AIS_SEL_LOWREF;
    end
    if (offset_cal_ctrl) begin
      posMapped = `AIS_SEL_LOWREF;
      negRaw    = 1'b0;
    end
  end

  // registered selection outputs
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      posSelect <= `AIS_SEL_LOWREF;
      negIsAn1  <= 1'b0;
      usingSetB <= 1'b0;
      scanIndex <= `AIS_RST_IDX;
    end else begin
      posSelect <= posMapped;
      negIsAn1  <= negRaw;
      usingSetB <= altPhase_q;
      scanIndex <= scanCurrent;
    end
  end

endmodule

// ****************************************
// lowest set bit finder
// ****************************************
// priority pick of the lowest set bit, index zero when none is set
module ais_lowest_bit #(
  parameter WIDTH = 16,
  parameter IDX_W = 4
) (
  input  wire [WIDTH-1:0] bits,
  output reg  [IDX_W-1:0] index,
  output reg              found
);

  integer k;

  // walk down from the top so the lowest hit is written last
  always @* begin
    index = {IDX_W{1'b0}};
    found = 1'b0;
    for (k = WIDTH - 1; k >= 0; k = k - 1) begin
      if (bits[k]) begin
        index = k[IDX_W-1:0];
        found = 1'b1;
      end
    end
  end

endmodule

// *** dv/ais_input_select_asserts.sv ***
// assertion checker for the input select block
`timescale 1ns/1ns
module ais_input_select_asserts (
  input wire logic        clock,
  input wire logic        reset,
  input wire logic [3:0]  regAddr,
  input wire logic [31:0] regWrData,
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic [31:0] regRdData,
  input wire logic        alternate_sample_ctrl,
  input wire logic        scan_enable_ctrl,
  input wire logic        offset_cal_ctrl,
  input wire logic        sampleStart,
  input wire logic [4:0]  posSelect,
  input wire logic        negIsAn1,
  input wire logic        usingSetB,
  input wire logic [3:0]  scanIndex
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // quiet cycle and select write steps
  sequence s_quiet; !regWrite && !offset_cal_ctrl && !scan_enable_ctrl
    && !alternate_sample_ctrl; endsequence
  sequence s_wrSel; regWrite && regAddr == 4'h0; endsequence
  property p_idleRd; !regRead |=> regRdData == 32'h0; endproperty
  a_idleRd: assert property (p_idleRd) else $error("idle read data");
  property p_selRd; regRead && regAddr == 4'h0 |=> regRdData[30:28] == 3'h0
    && regRdData[22:20] == 3'h0 && regRdData[15:0] == 16'h0; endproperty
  a_selRd: assert property (p_selRd) else $error("select gap bits");
  property p_maskRd; regRead && regAddr == 4'h4 |=> regRdData[31:16] == 16'h0; endproperty
  a_maskRd: assert property (p_maskRd) else $error("mask upper bits");
  property p_maskEcho; regWrite && regAddr == 4'h4 ##1 !regWrite ##1 regRead && regAddr == 4'h4
    |=> regRdData[15:0] == $past(regWrData[15:0], 3); endproperty
  a_maskEcho: assert property (p_maskEcho) else $error("mask readback");
  property p_offset_cal_ctrl; offset_cal_ctrl |=> posSelect == 5'h12 && !negIsAn1; endproperty
  a_offset_cal_ctrl: assert property (p_offset_cal_ctrl) else $error("calibration select");
  property p_altHold; (alternate_sample_ctrl && !sampleStart)[*4] |-> $stable(usingSetB); endproperty
  a_altHold: assert property (p_altHold) else $error("set moved idle");
  property p_scanHold; (scan_enable_ctrl && !sampleStart && !regWrite)[*4]
    |-> $stable(scanIndex); endproperty
  a_scanHold: assert property (p_scanHold) else $error("scan moved idle");
  property p_posA; s_wrSel ##1 s_quiet[*2] |=> posSelect == {1'b0, $past(regWrData[19:16], 3)};
  endproperty
  a_posA: assert property (p_posA) else $error("positive A select");
  property p_neg; s_wrSel ##0 regWrData[31] == regWrData[23] ##1 s_quiet[*2]
    |=> negIsAn1 == $past(regWrData[23], 3); endproperty
  a_neg: assert property (p_neg) else $error("negative select");
endmodule
bind ais_input_select ais_input_select_asserts u_chk (.*);

// *** dv/testbench.sv ***
// self-checking bench for the input select block
`timescale 1ns/1ns
module testbench;
  logic        clock = 0, reset = 1, regWrite = 0, regRead = 0, sampleStart = 0;
  logic        altCtrl = 0, scanCtrl = 0, calCtrl = 0;
  logic [3:0]  regAddr = 4'h0;
  logic [31:0] regWrData = 32'h0;
  logic [4:0]  scanSeq [6] = '{5'h00, 5'h03, 5'h10, 5'h0E, 5'h11, 5'h00};
  logic [3:0]  scanBits [6] = '{4'h0, 4'h3, 4'hD, 4'hE, 4'hF, 4'h0};
  wire  [31:0] regRdData;
  wire  [4:0]  posSelect;
  wire  [3:0]  scanIndex;
  wire         negIsAn1, usingSetB;
  int          miscompares = 0, cmp_count = 0;
  // clock source
  always #25 clock = ~clock;
  ais_input_select dut (.clock(clock), .reset(reset), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .alternate_sample_ctrl(altCtrl), .scan_enable_ctrl(scanCtrl), .offset_cal_ctrl(calCtrl),
    .sampleStart(sampleStart), .posSelect(posSelect), .negIsAn1(negIsAn1),
    .usingSetB(usingSetB), .scanIndex(scanIndex));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    regWrite <= 1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clock);
    regWrite <= 0;
  endtask
  task rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clock);
    regRead <= 1;
    regAddr <= a;
    @(posedge clock);
    regRead <= 0;
    @(negedge clock);
    chk(regRdData, e);
  endtask
  // one sample start pulse, then let the selection land
  task pulse;
    @(posedge clock);
    sampleStart <= 1;
    @(posedge clock);
    sampleStart <= 0;
    repeat (3) @(posedge clock);
    @(negedge clock);
  endtask
  task t_regs;
    rd(4'h0, 32'h0);
    rd(4'h4, 32'h0);
    wr(4'h0, 32'hFFFFFFFF);
    rd(4'h0, 32'h8F8F0000);
    wr(4'h4, 32'hFFFFFFFF);
    rd(4'h4, 32'h0000FFFF);
    wr(4'h8, 32'hFFFFFFFF);
    rd(4'h8, 32'h0);
  endtask
  task t_codes;
    // open code only written to check decode, no sample runs meanwhile
    for (int c = 0; c < 16; c++) begin
      wr(4'h0, {4'h8, 4'hF - c[3:0], 4'h0, c[3:0], 16'h0});
      repeat (2) @(posedge clock);
      @(negedge clock);
      chk(posSelect, c);
      chk(negIsAn1, 0);
    end
  endtask
  task t_alt;
    wr(4'h0, {4'h0, 4'h9, 4'h8, 4'h5, 16'h0});
    altCtrl <= 1;
    repeat (2) @(posedge clock);
    @(negedge clock);
    chk(usingSetB, 0);
    chk(posSelect, 5'h05);
    for (int k = 0; k < 4; k++) begin
      pulse;
      chk(usingSetB, (k + 1) % 2);
      chk(posSelect, (k % 2 == 0) ? 5'h09 : 5'h05);
      chk(negIsAn1, k % 2);
    end
    @(posedge clock);
    altCtrl <= 0;
  endtask
  task t_scan;
    wr(4'h4, 32'h0000E009);
    scanCtrl <= 1;
    for (int i = 0; i < 6; i++) begin
      pulse;
      chk(posSelect, scanSeq[i]);
      chk(scanIndex, scanBits[i]);
    end
    @(posedge clock);
    calCtrl <= 1;
    pulse;
    chk(posSelect, 5'h12);
    chk(negIsAn1, 0);
  endtask
  // reset in mid-run clears every written field
  task t_reset;
    @(posedge clock);
    reset <= 1;
    repeat (2) @(posedge clock);
    reset <= 0;
    rd(4'h0, 32'h0);
    rd(4'h4, 32'h0);
    chk(posSelect, 5'h12);
    chk(scanIndex, 4'h0);
  endtask
  task report_and_stop;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // main sequence after reset
  initial begin
    repeat (12) @(posedge clock);
    reset <= 0;
    t_regs;
    t_codes;
    t_alt;
    t_scan;
    t_reset;
    report_and_stop;
  end
  // run limit
  initial begin
    #2000000;
    miscompares++;
    report_and_stop;
  end
endmodule
